// File: verilog/tgm_map.svh
// constants of the timing generator and mode controller
// Behaviour
// R1: internal clocks come from a 2-stage prescaler and a 21-stage divider chain.
// R2: prescaler and divider clear to zero on reset, stop entry and stop release.
// R3: stage seven input follows operating mode, system clock select and divider-seven select.
// R4: slow run and slow doze modes feed low-frequency clock into stage seven.
// R5: warm-up after stop entered from fast run feeds stage seven from stage six.
// R6: software keeps divider-seven select low in single mode or unstable slow oscillator.
// R7: a machine cycle is four states of one main clock period each.
// R8: single mode runs fast oscillator only, frees slow pins, cycle four fast periods.
// R9: after reset the block runs in fast single run.
// R10: idle request enters light doze; any interrupt request returns to run.
// R11: light doze wake takes interrupt when master enable set, else resumes next instruction.
// R12: halt bit enters deep doze: CPU stops, only timebase timer stays clocked.
// R13: deep doze ends on falling edge of the selected timebase source.
// R14: deep doze returns to fast single run, or slow-only run from slow.
// R15: deep doze ignores timebase enable; enabled at entry sets latch on return.
// R16: dual mode main clock is fast in fast modes, slow in slow modes.
// R17: system clock select one goes fast dual to slow dual, zero goes back.
// R18: fast oscillator enable moves between slow dual run and slow-only run.
// R19: software never clears slow oscillator enable during slow dual run.
// R20: slow-only run and slow doze modes stop stage one, so stages one to six.
// R21: fast dual doze acts like light doze and wakes into fast dual run.
// R22: slow doze halts fast oscillator, wakes to slow-only; slow dual doze keeps it.
// R23: stop bit starts stop mode; release method bit picks edge or level release.
// R24: main clock source switches without truncated or glitched pulses.
// R25: mode entry requests take effect only at the end of a machine cycle.
`ifndef TGM_MAP_SVH
`define TGM_MAP_SVH

// divider vector layout: prescaler, stages one to six, stages seven to twenty-one
`define TGM_PRE_W        2
`define TGM_LOW_W        8
`define TGM_HIGH_W       15
`define TGM_DIV_W        23
`define TGM_LOW_RST      8'h00
`define TGM_HIGH_RST     15'h0000
`define TGM_LOW_FULL     8'hFF
// stage twenty-one ends the warm-up after a stop release
`define TGM_WARM_TAP     14
// divider bit index of each timebase source selection
`define TGM_TB_TAP0      22
`define TGM_TB_TAP1      20
`define TGM_TB_TAP2      17
`define TGM_TB_TAP3      15
`define TGM_TB_TAP4      13
`define TGM_TB_TAP5      12
`define TGM_TB_TAP6      11
`define TGM_TB_TAP7      9
// machine cycle has four states
`define TGM_LAST_STATE   2'h3

`endif

// File: verilog/tgm_pkg.sv
// types of the timing generator and mode controller
package tgm_pkg;

  typedef enum logic [3:0] {
    fast_single_run,
    fast_single_doze,
    fast_deep_doze,
    fast_dual_run,
    fast_dual_doze,
    slow_dual_run,
    slow_only_run,
    slow_dual_doze,
    slow_only_doze,
    slow_deep_doze,
    stop_hold,
    stop_warm
  } tgm_mode_t;

endpackage

// File: verilog/tgm_sync.sv
// two-flop synchroniser for pin-side inputs
`timescale 1ns/10ps
`default_nettype none

module tgm_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // first flop feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_q    <= '0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: verilog/tgm_core.sv
// timing generator, machine cycle counter and operating mode controller
`timescale 1ns/10ps
`default_nettype none
`include "tgm_map.svh"

module tgm_core (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_fast_base_clk,
  input  wire logic        i_slow_base_clk,
  input  wire logic        i_stop_pin_n,
  input  wire logic        i_system_clock_select,
  input  wire logic        i_divider_seven_clock_select,
  input  wire logic        i_fast_oscillator_enable,
  input  wire logic        i_slow_oscillator_enable,
  input  wire logic        i_idle_req,
  input  wire logic        i_timing_generator_halt_bit,
  input  wire logic        i_stop_req,
  input  wire logic        i_stop_release_method,
  input  wire logic [2:0]  i_timebase_clock_select,
  input  wire logic        i_timebase_enable,
  input  wire logic        i_master_interrupt_enable,
  input  wire logic        i_timebase_individual_enable,
  input  wire logic        i_int_req,
  input  wire logic        i_timebase_latch_clr,
  output logic [3:0]       o_mode,
  output logic [22:0]      o_divider,
  output logic [1:0]       o_cycle_state,
  output logic             o_cycle_end,
  output logic             o_cpu_clk_en,
  output logic             o_wdt_clk_en,
  output logic             o_periph_clk_en,
  output logic             o_tbt_clk_en,
  output logic             o_fast_osc_on,
  output logic             o_slow_osc_on,
  output logic             o_slow_pins_as_port,
  output logic             o_wake_to_isr,
  output logic             o_wake_to_next,
  output logic             o_timebase_interrupt_latch,
  output logic             o_timebase_irq_service
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and base clock edges

  logic [2:0] pins_s;
  logic       fc_p_q;
  logic       fs_p_q;
  logic       stop_p_q;
  logic       fc_tick;
  logic       fs_tick;
  logic       stop_rise;

  tgm_sync #(
    .W (3)
  ) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_stop_pin_n, i_slow_base_clk, i_fast_base_clk}),
    .o_q   (pins_s)
  );

  // previous synchronised levels for edge detection
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      fc_p_q   <= 1'b0;
      fs_p_q   <= 1'b0;
      stop_p_q <= 1'b0;
    end else begin
      fc_p_q   <= pins_s[0];
      fs_p_q   <= pins_s[1];
      stop_p_q <= pins_s[2];
    end
  end

  // base clock and stop pin rising edges become one-cycle enables
  assign fc_tick   = pins_s[0] & ~fc_p_q;
  assign fs_tick   = pins_s[1] & ~fs_p_q;
  assign stop_rise = pins_s[2] & ~stop_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // mode classification helpers

  function automatic logic is_slow(input tgm_pkg::tgm_mode_t m);
    is_slow = (m == tgm_pkg::slow_dual_run) || (m == tgm_pkg::slow_only_run) ||
              (m == tgm_pkg::slow_dual_doze) || (m == tgm_pkg::slow_only_doze) ||
              (m == tgm_pkg::slow_deep_doze);
  endfunction

  function automatic logic low_stopped(input tgm_pkg::tgm_mode_t m);
    low_stopped = (m == tgm_pkg::slow_only_run) || (m == tgm_pkg::slow_dual_doze) ||
                  (m == tgm_pkg::slow_only_doze) || (m == tgm_pkg::slow_deep_doze);
  endfunction

  function automatic logic tb_tap(input logic [22:0] d, input logic [2:0] s);
    unique case (s)
      3'h0: tb_tap = d[`TGM_TB_TAP0];
      3'h1: tb_tap = d[`TGM_TB_TAP1];
      3'h2: tb_tap = d[`TGM_TB_TAP2];
      3'h3: tb_tap = d[`TGM_TB_TAP3];
      3'h4: tb_tap = d[`TGM_TB_TAP4];
      3'h5: tb_tap = d[`TGM_TB_TAP5];
      3'h6: tb_tap = d[`TGM_TB_TAP6];
      3'h7: tb_tap = d[`TGM_TB_TAP7];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and divider chain

  tgm_pkg::tgm_mode_t mode_q;
  tgm_pkg::tgm_mode_t mode_d;
  logic [7:0]  low_q;
  logic [7:0]  low_d;
  logic [14:0] high_q;
  logic [14:0] high_d;
  logic        div_clr;
  logic        low_en;
  logic        low_carry;
  logic        high_en;
  logic        warm_from_fast_q;
  logic        warm_from_fast_d;

  assign low_en    = fc_tick & ~low_stopped(mode_q) & (mode_q != tgm_pkg::stop_hold); // R20
  assign low_carry = low_en & (low_q == `TGM_LOW_FULL);

  // stage seven input selection
  always_comb begin
    if (mode_q == tgm_pkg::stop_hold) begin
      high_en = 1'b0;
    end else if (is_slow(mode_q)) begin
      high_en = fs_tick; // R4
    end else if (mode_q == tgm_pkg::stop_warm && warm_from_fast_q) begin
      high_en = low_carry; // R5
    end else if (i_divider_seven_clock_select) begin
      high_en = fs_tick; // R3
    end else begin
      high_en = low_carry; // R3
    end
  end

  // counting stages, cleared together
  always_comb begin
    low_d  = low_q;
    high_d = high_q;
    if (div_clr) begin
      low_d  = `TGM_LOW_RST; // R2
      high_d = `TGM_HIGH_RST; // R2
    end else begin
      if (low_en) begin
        low_d = low_q + 8'h01; // R1
      end
      if (high_en) begin
        high_d = high_q + 15'h0001; // R1
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_q  <= `TGM_LOW_RST; // R2
      high_q <= `TGM_HIGH_RST;
    end else begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main system clock and machine cycle

  logic       main_tick;
  logic [1:0] st_q;
  logic [1:0] st_d;
  logic       cyc_end;

  // source follows the mode, which leaves a run mode only on a cycle boundary
  assign main_tick = (mode_q == tgm_pkg::stop_hold || mode_q == tgm_pkg::stop_warm) ? 1'b0 :
                     (is_slow(mode_q) ? fs_tick : fc_tick); // R16 R8 R24
  assign cyc_end   = main_tick & (st_q == `TGM_LAST_STATE); // R7

  always_comb begin
    st_d = st_q;
    if (div_clr) begin
      st_d = 2'h0;
    end else if (main_tick) begin
      st_d = st_q + 2'h1; // R7
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating mode state machine

  logic tap_p_q;
  logic tap_fall;
  logic tb_at_entry_q;
  logic tb_at_entry_d;
  logic latch_q;
  logic latch_d;
  logic light_wake;
  logic deep_wake;
  logic release_hit;
  logic warm_done;

  assign tap_fall    = tap_p_q & ~tb_tap({high_q, low_q}, i_timebase_clock_select); // R13
  assign release_hit = i_stop_release_method ? pins_s[2] : stop_rise; // R23
  assign warm_done   = high_q[`TGM_WARM_TAP];

  always_comb begin
    mode_d           = mode_q;
    div_clr          = 1'b0;
    light_wake       = 1'b0;
    deep_wake        = 1'b0;
    tb_at_entry_d    = tb_at_entry_q;
    warm_from_fast_d = warm_from_fast_q;
    unique case (mode_q)
      tgm_pkg::fast_single_run, tgm_pkg::fast_dual_run,
      tgm_pkg::slow_dual_run, tgm_pkg::slow_only_run: begin
        if (cyc_end) begin // R25
          if (i_stop_req) begin
            mode_d           = tgm_pkg::stop_hold; // R23
            div_clr          = 1'b1; // R2
            warm_from_fast_d = ~is_slow(mode_q);
          end else if (i_timing_generator_halt_bit) begin
            mode_d        = is_slow(mode_q) ? tgm_pkg::slow_deep_doze :
                                              tgm_pkg::fast_deep_doze; // R12
            tb_at_entry_d = i_timebase_enable; // R15
          end else if (i_idle_req) begin
            unique case (mode_q)
              tgm_pkg::fast_single_run: mode_d = tgm_pkg::fast_single_doze; // R10
              tgm_pkg::fast_dual_run:   mode_d = tgm_pkg::fast_dual_doze; // R21
              tgm_pkg::slow_dual_run:   mode_d = tgm_pkg::slow_dual_doze; // R22
              default:                  mode_d = tgm_pkg::slow_only_doze; // R22
            endcase
          end else if (mode_q == tgm_pkg::fast_single_run) begin
            if (i_slow_oscillator_enable) begin
              mode_d = tgm_pkg::fast_dual_run;
            end
          end else if (mode_q == tgm_pkg::fast_dual_run) begin
            if (i_system_clock_select) begin
              mode_d = tgm_pkg::slow_dual_run; // R17
            end else if (!i_slow_oscillator_enable) begin
              mode_d = tgm_pkg::fast_single_run;
            end
          end else if (mode_q == tgm_pkg::slow_dual_run) begin
            if (!i_fast_oscillator_enable) begin
              mode_d = tgm_pkg::slow_only_run; // R18
            end else if (!i_system_clock_select) begin
              mode_d = tgm_pkg::fast_dual_run; // R17
            end
          end else if (i_fast_oscillator_enable) begin
            mode_d = tgm_pkg::slow_dual_run; // R18
          end
        end
      end
      tgm_pkg::fast_single_doze: begin
        if (i_int_req) begin
          mode_d     = tgm_pkg::fast_single_run; // R10
          light_wake = 1'b1;
        end
      end
      tgm_pkg::fast_dual_doze: begin
        if (i_int_req) begin
          mode_d     = tgm_pkg::fast_dual_run; // R21
          light_wake = 1'b1;
        end
      end
      tgm_pkg::slow_dual_doze, tgm_pkg::slow_only_doze: begin
        if (i_int_req) begin
          mode_d     = tgm_pkg::slow_only_run; // R22
          light_wake = 1'b1;
        end
      end
      tgm_pkg::fast_deep_doze, tgm_pkg::slow_deep_doze: begin
        if (tap_fall) begin
          mode_d    = (mode_q == tgm_pkg::slow_deep_doze) ? tgm_pkg::slow_only_run :
                                                            tgm_pkg::fast_single_run; // R14
          deep_wake = 1'b1; // R13
        end
      end
      tgm_pkg::stop_hold: begin
        if (release_hit) begin
          mode_d  = tgm_pkg::stop_warm;
          div_clr = 1'b1; // R2
        end
      end
      tgm_pkg::stop_warm: begin
        if (warm_done) begin
          mode_d = warm_from_fast_q ? tgm_pkg::fast_single_run : tgm_pkg::slow_only_run;
        end
      end
      default: begin
        mode_d = tgm_pkg::fast_single_run;
      end
    endcase
  end

  // timebase latch: a new set wins over a clear in the same cycle
  always_comb begin
    latch_d = latch_q;
    if (i_timebase_latch_clr) begin
      latch_d = 1'b0;
    end
    if (deep_wake && tb_at_entry_q) begin
      latch_d = 1'b1; // R15
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q           <= tgm_pkg::fast_single_run; // R9
      tb_at_entry_q    <= 1'b0;
      warm_from_fast_q <= 1'b0;
      latch_q          <= 1'b0;
      tap_p_q          <= 1'b0;
    end else begin
      mode_q           <= mode_d;
      tb_at_entry_q    <= tb_at_entry_d;
      warm_from_fast_q <= warm_from_fast_d;
      latch_q          <= latch_d;
      tap_p_q          <= tb_tap({high_q, low_q}, i_timebase_clock_select);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic cpu_run;
  logic deep;
  logic stopped;
  logic fast_on;
  logic slow_on;

  assign cpu_run = (mode_q == tgm_pkg::fast_single_run) || (mode_q == tgm_pkg::fast_dual_run) ||
                   (mode_q == tgm_pkg::slow_dual_run) || (mode_q == tgm_pkg::slow_only_run);
  assign deep    = (mode_q == tgm_pkg::fast_deep_doze) || (mode_q == tgm_pkg::slow_deep_doze);
  assign stopped = (mode_q == tgm_pkg::stop_hold) || (mode_q == tgm_pkg::stop_warm);
  // fast oscillator off in slow-only modes, in slow deep doze and in stop hold
  assign fast_on = ~(low_stopped(mode_q) && mode_q != tgm_pkg::slow_dual_doze) &
                   (mode_q != tgm_pkg::stop_hold); // R22 R18
  // slow oscillator runs outside single-clock operation, except in fast deep doze, stop hold and warm-up from fast
  assign slow_on = (mode_q != tgm_pkg::fast_single_run) && (mode_q != tgm_pkg::fast_single_doze) &&
                   (mode_q != tgm_pkg::fast_deep_doze) && (mode_q != tgm_pkg::stop_hold) &&
                   ~(mode_q == tgm_pkg::stop_warm && warm_from_fast_q); // R8

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mode                     <= 4'h0;
      o_divider                  <= 23'h000000;
      o_cycle_state              <= 2'h0;
      o_cycle_end                <= 1'b0;
      o_cpu_clk_en               <= 1'b0;
      o_wdt_clk_en               <= 1'b0;
      o_periph_clk_en            <= 1'b0;
      o_tbt_clk_en               <= 1'b0;
      o_fast_osc_on              <= 1'b1;
      o_slow_osc_on              <= 1'b0;
      o_slow_pins_as_port        <= 1'b1;
      o_wake_to_isr              <= 1'b0;
      o_wake_to_next             <= 1'b0;
      o_timebase_interrupt_latch <= 1'b0;
      o_timebase_irq_service     <= 1'b0;
    end else begin
      o_mode                     <= mode_q;
      o_divider                  <= {high_q, low_q};
      o_cycle_state              <= st_q;
      o_cycle_end                <= cyc_end;
      o_cpu_clk_en               <= main_tick & cpu_run; // R10 R12
      o_wdt_clk_en               <= main_tick & cpu_run; // R10
      o_periph_clk_en            <= main_tick & ~deep & ~stopped; // R12
      o_tbt_clk_en               <= main_tick & ~stopped;
      o_fast_osc_on              <= fast_on;
      o_slow_osc_on              <= slow_on;
      o_slow_pins_as_port        <= ~slow_on; // R8
      o_wake_to_isr              <= light_wake & i_master_interrupt_enable; // R11
      o_wake_to_next             <= light_wake & ~i_master_interrupt_enable; // R11
      o_timebase_interrupt_latch <= latch_d;
      o_timebase_irq_service     <= latch_d & i_master_interrupt_enable &
                                    i_timebase_individual_enable & i_timebase_enable; // R15
    end
  end

endmodule

`default_nettype wire

// File: verification/tgm_core_props.sv
// port-level assertions for the timing generator and mode controller
`timescale 1ns/10ps
`default_nettype none

module tgm_core_props (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_master_interrupt_enable,
  input wire logic        i_timebase_individual_enable,
  input wire logic        i_timebase_enable,
  input wire logic [3:0]  o_mode,
  input wire logic [22:0] o_divider,
  input wire logic [1:0]  o_cycle_state,
  input wire logic        o_cpu_clk_en,
  input wire logic        o_periph_clk_en,
  input wire logic        o_tbt_clk_en,
  input wire logic        o_fast_osc_on,
  input wire logic        o_slow_osc_on,
  input wire logic        o_slow_pins_as_port,
  input wire logic        o_wake_to_isr,
  input wire logic        o_wake_to_next,
  input wire logic        o_timebase_irq_service
);
  // mode classes; a mode edge may land a tick either side of an enable
  function automatic logic is_run(input logic [3:0] m);
    return m == 4'h0 || m == 4'h3 || m == 4'h5 || m == 4'h6;
  endfunction
  function automatic logic is_deep(input logic [3:0] m);
    return m == 4'h2 || m == 4'h9 || m == 4'hA || m == 4'hB;
  endfunction

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // outputs tied to their causes
  a_reset_fast_single: assert property (
    $fell(i_rst) |-> o_mode == 4'h0 && o_divider == 23'h000000)
    else $error("reset did not leave fast single run with a clear divider");
  a_state_steps_one: assert property (
    o_cycle_state != $past(o_cycle_state) |-> o_cycle_state == $past(o_cycle_state) + 2'h1)
    else $error("machine state skipped a step");
  a_cpu_run_only: assert property (
    o_cpu_clk_en |-> is_run(o_mode) || is_run($past(o_mode)))
    else $error("cpu clocked outside a run mode");
  a_periph_deep_off: assert property (
    o_periph_clk_en |-> !(is_deep(o_mode) && is_deep($past(o_mode))))
    else $error("peripherals clocked in deep doze");
  a_single_slow_off: assert property (
    (o_mode == 4'h0)[*3] |-> o_slow_pins_as_port && !o_slow_osc_on && o_fast_osc_on)
    else $error("single mode oscillator or pin state wrong");
  a_irq_needs_enables: assert property (
    o_timebase_irq_service |-> $past(i_master_interrupt_enable)
      && $past(i_timebase_individual_enable) && $past(i_timebase_enable))
    else $error("timebase service without all enables");
  a_wake_isr_ime: assert property (
    o_wake_to_isr |-> !o_wake_to_next && $past(i_master_interrupt_enable))
    else $error("wake to service with master enable low");
  a_slow_low_frozen: assert property (
    (o_mode == 4'h6)[*4] |-> $stable(o_divider[7:2]))
    else $error("stages one to six moved in slow only run");
  a_stop_clears_div: assert property (
    $rose(o_mode == 4'hA) |-> ##[0:3] o_divider == 23'h000000)
    else $error("divider not cleared on stop entry");
  a_tbt_stop_off: assert property (
    o_tbt_clk_en |-> !(o_mode == 4'hA && $past(o_mode) == 4'hA))
    else $error("timebase clocked in stop");
endmodule

bind tgm_core tgm_core_props u_props (.*);

`default_nettype wire

// File: verification/tgm_core_bench.sv
// self-checking bench for the timing generator and mode controller
`timescale 1ns/10ps
`default_nettype none

module tgm_core_bench;
  logic        i_clk, i_rst, i_fast_base_clk, i_slow_base_clk, i_stop_pin_n;
  logic        i_system_clock_select, i_divider_seven_clock_select, i_idle_req;
  logic        i_fast_oscillator_enable, i_slow_oscillator_enable, i_int_req;
  logic        i_timing_generator_halt_bit, i_stop_req, i_stop_release_method;
  logic        i_timebase_enable, i_master_interrupt_enable, i_timebase_individual_enable;
  logic        i_timebase_latch_clr;
  logic [2:0]  i_timebase_clock_select;
  logic [3:0]  o_mode;
  logic [22:0] o_divider;
  logic [1:0]  o_cycle_state;
  logic        o_cycle_end, o_cpu_clk_en, o_wdt_clk_en, o_periph_clk_en, o_tbt_clk_en;
  logic        o_fast_osc_on, o_slow_osc_on, o_slow_pins_as_port, o_wake_to_isr;
  logic        o_wake_to_next, o_timebase_interrupt_latch, o_timebase_irq_service;
  logic [3:0]  want;
  logic        at_mode;
  int          fails, total_checks;

  tgm_core u_dut (.*);

  // system clock and oscillator pins, pin edges on system clock falling edges
  always #10 i_clk = ~i_clk;
  always #60 i_fast_base_clk = ~i_fast_base_clk;
  always #500 i_slow_base_clk = ~i_slow_base_clk;
  assign at_mode = (o_mode === want);

  ////////////////////////////////////////////////////////////////////////
  // counted comparison
  task automatic check(input string what, input logic [22:0] seen, input logic [22:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // bounded wait for a high level
  task automatic wait_high(ref logic sig, input int bound);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < bound) begin
      @(negedge i_clk);
      n++;
    end
    if (sig !== 1'b1) begin
      fails++;
      $display("BAD wait expected 1 seen %b", sig);
      tally_and_finish();
    end
  endtask

  // bounded wait for a mode
  task automatic wait_mode(input logic [3:0] m, input int bound);
    want = m;
    #1;
    wait_high(at_mode, bound);
    check("mode", o_mode, m);
  endtask

  // request held until taken
  task automatic req_mode(ref logic req, input logic [3:0] m, input int bound);
    req = 1'b1;
    wait_mode(m, bound);
    req = 1'b0;
  endtask

  // interrupt request until the run mode returns
  task automatic wake(input logic [3:0] m);
    i_int_req = 1'b1;
    wait_mode(m, 20);
    i_int_req = 1'b0;
  endtask

  // clock enable pulses over a window
  task automatic count_en(input int cycles, output int cpu, output int per, output int timebase_timer);
    cpu = 0;
    per = 0;
    timebase_timer = 0;
    repeat (cycles) begin
      @(negedge i_clk);
      cpu += int'(o_cpu_clk_en | o_wdt_clk_en);
      per += int'(o_periph_clk_en);
      timebase_timer += int'(o_tbt_clk_en);
    end
  endtask

  // reset values
  task automatic t_reset();
    check("mode", o_mode, tgm_pkg::fast_single_run);
    check("divider", o_divider, 23'h000000);
    check("fast osc", o_fast_osc_on, 1'b1);
    check("slow osc", o_slow_osc_on, 1'b0);
    check("pins as port", o_slow_pins_as_port, 1'b1);
    $display("test reset done");
  endtask

  // one machine cycle: length in system clocks and state count
  task automatic t_cycle(input int exp);
    int gap, cpu;
    gap = 0;
    cpu = 0;
    wait_high(o_cycle_end, 400);
    do begin
      @(negedge i_clk);
      gap++;
      cpu += int'(o_cpu_clk_en);
    end while (o_cycle_end !== 1'b1 && gap < 400);
    check("cycle length", gap, exp);
    check("ticks per cycle", cpu, 4);
    $display("test cycle %0d done", exp);
  endtask

  // light doze with both master enable settings
  task automatic t_light();
    int cpu, per, timebase_timer;
    for (int ime = 0; ime < 2; ime++) begin
      i_master_interrupt_enable = ime[0];
      req_mode(i_idle_req, tgm_pkg::fast_single_doze, 100);
      count_en(60, cpu, per, timebase_timer);
      check("cpu halted", cpu, 0);
      check("periph running", per > 0, 1'b1);
      i_int_req = 1'b1;
      if (ime == 1)
        wait_high(o_wake_to_isr, 10);
      else
        wait_high(o_wake_to_next, 10);
      wake(tgm_pkg::fast_single_run);
    end
    $display("test light doze done");
  endtask

  // deep doze with timebase enabled then disabled
  task automatic t_deep();
    int cpu, per, timebase_timer;
    i_master_interrupt_enable = 1'b1;
    i_timebase_individual_enable = 1'b1;
    for (int en = 1; en >= 0; en--) begin
      i_timebase_enable = en[0];
      req_mode(i_timing_generator_halt_bit, tgm_pkg::fast_deep_doze, 100);
      count_en(60, cpu, per, timebase_timer);
      check("periph gated", per, 0);
      check("timebase running", timebase_timer > 0, 1'b1);
      wait_mode(tgm_pkg::fast_single_run, 20000);
      check("tap low at wake", o_divider[9], 1'b0);
      repeat (3) @(negedge i_clk);
      check("latch", o_timebase_interrupt_latch, en[0]);
      check("service", o_timebase_irq_service, en[0]);
      i_timebase_latch_clr = 1'b1;
      @(negedge i_clk);
      i_timebase_latch_clr = 1'b0;
      @(negedge i_clk);
      check("latch cleared", o_timebase_interrupt_latch, 1'b0);
    end
    $display("test deep doze done");
  endtask

  // dual clock walk through fast, slow and doze modes
  task automatic t_dual();
    i_slow_oscillator_enable = 1'b1;
    wait_mode(tgm_pkg::fast_dual_run, 100);
    check("slow pins in use", o_slow_pins_as_port, 1'b0);
    req_mode(i_idle_req, tgm_pkg::fast_dual_doze, 100);
    wake(tgm_pkg::fast_dual_run);
    i_system_clock_select = 1'b1;
    wait_mode(tgm_pkg::slow_dual_run, 100);
    t_cycle(200);
    i_fast_oscillator_enable = 1'b0;
    wait_mode(tgm_pkg::slow_only_run, 400);
    repeat (2) @(negedge i_clk);
    check("fast osc off", o_fast_osc_on, 1'b0);
    req_mode(i_idle_req, tgm_pkg::slow_only_doze, 400);
    wake(tgm_pkg::slow_only_run);
    req_mode(i_timing_generator_halt_bit, tgm_pkg::slow_deep_doze, 400);
    wait_mode(tgm_pkg::slow_only_run, 2000);
    i_fast_oscillator_enable = 1'b1;
    wait_mode(tgm_pkg::slow_dual_run, 400);
    i_system_clock_select = 1'b0;
    wait_mode(tgm_pkg::fast_dual_run, 400);
    i_slow_oscillator_enable = 1'b0;
    wait_mode(tgm_pkg::fast_single_run, 100);
    $display("test dual clock done");
  endtask

  // stop entry, edge then level release, reset in mid warm-up
  task automatic t_stop();
    for (int lvl = 0; lvl < 2; lvl++) begin
      i_stop_release_method = lvl[0];
      req_mode(i_stop_req, tgm_pkg::stop_hold, 100);
      repeat (20) @(negedge i_clk);
      check("divider in stop", o_divider, 23'h000000);
      i_stop_pin_n = 1'b1;
      wait_mode(tgm_pkg::stop_warm, 20);
      repeat (50) @(negedge i_clk);
      i_rst = 1'b1;
      repeat (4) @(negedge i_clk);
      t_reset();
      i_stop_pin_n = 1'b0;
      i_rst = 1'b0;
    end
    $display("test stop done");
  endtask

  // counts and verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_clk, i_fast_base_clk, i_slow_base_clk, i_stop_pin_n, i_system_clock_select} = 5'h00;
    {i_divider_seven_clock_select, i_idle_req, i_slow_oscillator_enable, i_int_req} = 4'h0;
    {i_timing_generator_halt_bit, i_stop_req, i_stop_release_method, i_timebase_enable} = 4'h0;
    {i_master_interrupt_enable, i_timebase_individual_enable, i_timebase_latch_clr} = 3'h0;
    i_timebase_clock_select = 3'h7;
    i_fast_oscillator_enable = 1'b1;
    i_rst = 1'b1;
    fails = 0;
    total_checks = 0;
    repeat (4) @(negedge i_clk);
    t_reset();
    i_rst = 1'b0;
    t_cycle(24);
    t_light();
    t_deep();
    t_dual();
    t_stop();
    t_cycle(24);
    tally_and_finish();
  end
endmodule

`default_nettype wire
